//--- core/rq_pkg.sv
// constants and register map of the reactive power datapath
package rq_pkg;
  localparam int          DATA_W      = 28;
  localparam int          CAL_W       = 24;
  localparam int          SMP_W       = 24;
  localparam logic [27:0] FULL_SCALE_POWER_CONSTANT = 28'h1ff6a6b;
  localparam int          FULL_SCALE_POWER_CONSTANT_SHIFT  = 4;
  localparam int          GAIN_FRAC   = 23;
  localparam int          CLK_HZ      = 125000000;
  localparam int          SAMPLE_NS   = 125000;
  localparam int          SAMPLE_CYC  = SAMPLE_NS / 8;
  localparam int          LPF_SHIFT_WEAK   = 3;
  localparam int          LPF_SHIFT_STRONG = 6;
  localparam int          FUND_SHIFT  = 9;
  localparam int          SETTLE63_MS  = 375;
  localparam int          SETTLE100_MS = 875;
  localparam logic [5:0] A_TOT_GAIN = 6'h00;
  localparam logic [5:0] B_TOT_GAIN = 6'h01;
  localparam logic [5:0] C_TOT_GAIN = 6'h02;
  localparam logic [5:0] A_FUN_GAIN = 6'h03;
  localparam logic [5:0] B_FUN_GAIN = 6'h04;
  localparam logic [5:0] C_FUN_GAIN = 6'h05;
  localparam logic [5:0] A_TOT_OFS  = 6'h06;
  localparam logic [5:0] B_TOT_OFS  = 6'h07;
  localparam logic [5:0] C_TOT_OFS  = 6'h08;
  localparam logic [5:0] A_FUN_OFS  = 6'h09;
  localparam logic [5:0] B_FUN_OFS  = 6'h0a;
  localparam logic [5:0] C_FUN_OFS  = 6'h0b;
  localparam logic [5:0] CFG_ADDR   = 6'h0c;
  localparam logic [5:0] A_INST_Q   = 6'h10;
  localparam logic [5:0] B_INST_Q   = 6'h11;
  localparam logic [5:0] C_INST_Q   = 6'h12;
  localparam logic [5:0] A_FUND_Q   = 6'h13;
  localparam logic [5:0] B_FUND_Q   = 6'h14;
  localparam logic [5:0] C_FUND_Q   = 6'h15;
  localparam int          CFG_LPF_BIT = 0;
  localparam logic        CFG_LPF_RST = 1'b0;
  localparam logic [23:0] CAL_RST    = 24'h000000;
endpackage

//--- core/rq_phase_calc.sv
// one phase: quadrature product, filter, offset, gain, saturation
`timescale 1ns/1ns
module rq_phase_calc (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // sample strobe and filter strength flag; the flag is unused, i_shift sets the filter
  input  wire logic        i_smp_en,
  input  wire logic        i_lpf_strong,
  // samples: voltage, current shifted by 90 degrees
  input  wire logic [23:0] i_volt,
  input  wire logic [23:0] i_curr_q,
  // calibration
  input  wire logic [23:0] i_gain,
  input  wire logic [23:0] i_offset,
  input  wire logic [4:0]  i_shift,
  // result
  output logic      [27:0] o_power
);
  localparam logic signed [72:0] MAXV = 73'sh7ffffff;
  localparam logic signed [72:0] MINV = -73'sh8000000;

  function automatic logic [27:0] sat28(input logic signed [72:0] v);
    if (v > MAXV) begin
      sat28 = 28'h7ffffff;
    end else if (v < MINV) begin
      sat28 = 28'h8000000;
    end else begin
      sat28 = v[27:0];
    end
  endfunction

  logic signed [47:0] prod_w;
  logic signed [47:0] inst_w;
  logic signed [47:0] filt_q;
  logic signed [47:0] filt_d;
  logic signed [47:0] ofs_w;
  logic signed [72:0] scaled_w;
  logic signed [76:0] inst_wide_w;
  logic signed [24:0] gain_w;
  logic [27:0]        power_q;

  // full-scale in-phase inputs give the power constant before the 2^4 drop
  assign prod_w   = $signed(i_volt) * $signed(i_curr_q);
  // product kept at full width; a 48-bit context would drop its top bits
  assign inst_wide_w = prod_w * $signed({1'b0, rq_pkg::FULL_SCALE_POWER_CONSTANT});
  assign inst_w   = 48'(inst_wide_w >>> (46 + rq_pkg::FULL_SCALE_POWER_CONSTANT_SHIFT));
  assign filt_d   = filt_q + ((inst_w - filt_q) >>> i_shift);
  // offset joins before the gain so gain also scales its correction
  assign ofs_w    = filt_q + {{24{i_offset[23]}}, i_offset};
  assign gain_w   = 25'sh0800000 + $signed({i_gain[23], i_gain});
  assign scaled_w = (ofs_w * gain_w) >>> rq_pkg::GAIN_FRAC;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      filt_q  <= 48'sh0;
      power_q <= 28'h0;
    end else if (i_smp_en) begin
      filt_q  <= filt_d;
      power_q <= sat28(scaled_w);
    end
  end

  assign o_power = power_q;
endmodule

//--- core/reactive_power_datapath.sv
// three-phase total and fundamental reactive power with calibration registers
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module reactive_power_datapath (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // total-path samples, current already shifted by 90 degrees per harmonic
  input  wire logic [23:0] i_volt_a,
  input  wire logic [23:0] i_volt_b,
  input  wire logic [23:0] i_volt_c,
  input  wire logic [23:0] i_curr_q_a,
  input  wire logic [23:0] i_curr_q_b,
  input  wire logic [23:0] i_curr_q_c,
  // fundamental-only samples from the first-harmonic extractor
  input  wire logic [23:0] i_fvolt_a,
  input  wire logic [23:0] i_fvolt_b,
  input  wire logic [23:0] i_fvolt_c,
  input  wire logic [23:0] i_fcurr_q_a,
  input  wire logic [23:0] i_fcurr_q_b,
  input  wire logic [23:0] i_fcurr_q_c,
  // register port
  input  wire logic [5:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // results and sample strobe
  output logic      [27:0] o_phase_a_inst_q,
  output logic      [27:0] o_phase_b_inst_q,
  output logic      [27:0] o_phase_c_inst_q,
  output logic             o_sample
);
  localparam logic [13:0] SMP_LAST = 14'(rq_pkg::SAMPLE_CYC - 1);

  //////////////////////////////////////////////////////////////////////////////
  // sample rate divider

  logic [13:0] div_q;
  logic        smp_en;
  assign smp_en = (div_q == SMP_LAST);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_q <= 14'h0;
    end else if (smp_en) begin
      div_q <= 14'h0;
    end else begin
      div_q <= div_q + 14'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // calibration registers: index 0..5 gains, 6..11 offsets

  logic [23:0] cal_q [0:11];
  logic        lpf_strong_q;
  logic        cal_hit;
  logic [3:0]  cal_idx;
  assign cal_hit = (i_addr <= rq_pkg::C_FUN_OFS);
  assign cal_idx = i_addr[3:0];

  // only the low 24 bits are stored; the top byte of the word is ignored
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int k = 0; k < 12; k++) begin
        cal_q[k] <= rq_pkg::CAL_RST;
      end
      lpf_strong_q <= rq_pkg::CFG_LPF_RST;
    end else if (i_wr && cal_hit) begin
      cal_q[cal_idx] <= i_wdata[23:0];
    end else if (i_wr && (i_addr == rq_pkg::CFG_ADDR)) begin
      lpf_strong_q <= i_wdata[rq_pkg::CFG_LPF_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-phase datapaths

  logic [4:0]  tot_shift;
  logic [4:0]  fun_shift;
  logic [27:0] tot_p [0:2];
  logic [27:0] fun_p [0:2];
  logic [23:0] v_t [0:2];
  logic [23:0] i_t [0:2];
  logic [23:0] v_f [0:2];
  logic [23:0] i_f [0:2];

  assign tot_shift = lpf_strong_q ? 5'(rq_pkg::LPF_SHIFT_STRONG)
                                  : 5'(rq_pkg::LPF_SHIFT_WEAK);
  // slow fixed filter: time constant ~ 2^9 samples gives the long settling
  assign fun_shift = 5'(rq_pkg::FUND_SHIFT);
  assign v_t[0] = i_volt_a;
  assign v_t[1] = i_volt_b;
  assign v_t[2] = i_volt_c;
  assign i_t[0] = i_curr_q_a;
  assign i_t[1] = i_curr_q_b;
  assign i_t[2] = i_curr_q_c;
  assign v_f[0] = i_fvolt_a;
  assign v_f[1] = i_fvolt_b;
  assign v_f[2] = i_fvolt_c;
  assign i_f[0] = i_fcurr_q_a;
  assign i_f[1] = i_fcurr_q_b;
  assign i_f[2] = i_fcurr_q_c;

  // sign follows voltage phase minus current phase through the product
  for (genvar p = 0; p < 3; p++) begin : g_ph
    rq_phase_calc u_tot (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_smp_en     (smp_en),
      .i_lpf_strong (lpf_strong_q),
      .i_volt       (v_t[p]),
      .i_curr_q     (i_t[p]),
      .i_gain       (cal_q[p]),
      .i_offset     (cal_q[p + 6]),
      .i_shift      (tot_shift),
      .o_power      (tot_p[p])
    );
    rq_phase_calc u_fun (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_smp_en     (smp_en),
      .i_lpf_strong (1'b0),
      .i_volt       (v_f[p]),
      .i_curr_q     (i_f[p]),
      .i_gain       (cal_q[p + 3]),
      .i_offset     (cal_q[p + 9]),
      .i_shift      (fun_shift),
      .o_power      (fun_p[p])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port

  function automatic logic [31:0] sx24(input logic [23:0] v);
    sx24 = {4'h0, {4{v[23]}}, v};
  endfunction
  function automatic logic [31:0] sx28(input logic [27:0] v);
    sx28 = {{4{v[27]}}, v};
  endfunction

  logic [31:0] rd_w;
  logic [31:0] rdata_q;
  assign rd_w =
    cal_hit                        ? sx24(cal_q[cal_idx]) :
    (i_addr == rq_pkg::CFG_ADDR)   ? {31'h0, lpf_strong_q} :
    (i_addr == rq_pkg::A_INST_Q)   ? sx28(tot_p[0]) :
    (i_addr == rq_pkg::B_INST_Q)   ? sx28(tot_p[1]) :
    (i_addr == rq_pkg::C_INST_Q)   ? sx28(tot_p[2]) :
    (i_addr == rq_pkg::A_FUND_Q)   ? sx28(fun_p[0]) :
    (i_addr == rq_pkg::B_FUND_Q)   ? sx28(fun_p[1]) :
    (i_addr == rq_pkg::C_FUND_Q)   ? sx28(fun_p[2]) : 32'h0;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 32'h0;
    end else if (i_rd) begin
      rdata_q <= rd_w;
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign o_rdata          = rdata_q;
  assign o_phase_a_inst_q = tot_p[0];
  assign o_phase_b_inst_q = tot_p[1];
  assign o_phase_c_inst_q = tot_p[2];
  assign o_sample         = smp_en;
endmodule

//--- testbench/rq_props.sv
// concurrent checks on the reactive power datapath ports
`timescale 1ns/1ns
module rq_props (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  // register port
  input wire logic [5:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // result and sample strobe
  input wire logic [27:0] o_phase_a_inst_q,
  input wire logic        o_sample
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [13:0] cnt_q;
  logic        seen_q;
  logic [23:0] wd_q;
  // cycles since the last strobe; the first strobe after reset has no reference
  always_ff @(posedge i_clk) begin
    cnt_q  <= (i_sys_rst || o_sample) ? 14'h0 : cnt_q + 14'h1;
    seen_q <= !i_sys_rst && (seen_q || o_sample);
    if (i_wr) wd_q <= i_wdata[23:0];
  end
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not idle");
  AST_TOP_ZERO: assert property ($past(i_rd) && $past(i_addr) < 6'h0c |-> o_rdata[31:28] == 4'h0)
    else $error("top bits not zero");
  AST_SIGN_EXT: assert property ($past(i_rd) && $past(i_addr) < 6'h0c
    |-> o_rdata[27:24] == {4{o_rdata[23]}})
    else $error("no sign extension");
  AST_UNMAPPED: assert property ($past(i_rd) && ($past(i_addr) inside {[6'h0d:6'h0f], [6'h16:6'h3f]})
    |-> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_WR_RB: assert property (i_wr ##1 (i_rd && i_addr == $past(i_addr) && i_addr < 6'h0c)
    |=> o_rdata[23:0] == wd_q)
    else $error("readback differs");
  AST_PULSE: assert property (o_sample |=> !o_sample)
    else $error("strobe longer than one cycle");
  AST_PERIOD: assert property (o_sample && seen_q |-> cnt_q == 14'h3d08)
    else $error("sample period wrong");
  AST_HOLD: assert property ($changed(o_phase_a_inst_q) |-> $past(o_sample))
    else $error("result changed off strobe");
  AST_RESULT_RB: assert property ($past(i_rd && i_addr == 6'h10) && $stable(o_phase_a_inst_q)
    |-> o_rdata == {{4{o_phase_a_inst_q[27]}}, o_phase_a_inst_q})
    else $error("result readback differs");
  C_RB: cover property (i_wr ##1 i_rd);
  C_SMP: cover property (o_sample);
  C_POS: cover property (o_sample ##1 o_phase_a_inst_q != 28'h0);
endmodule

bind reactive_power_datapath rq_props u_rq_props (.i_clk, .i_sys_rst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_phase_a_inst_q, .o_sample);

//--- testbench/tb_top.sv
// self-checking bench for the reactive power datapath
`timescale 1ns/1ns
module tb_top;
  logic        i_clk;
  logic        i_sys_rst;
  logic [23:0] va, vb, ia, ib;
  logic [5:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic [27:0] qa, qb, qc;
  logic        o_sample;
  logic [31:0] rd_v;
  int          err_total;
  int          n_tests;
  // phase c and its fundamental inputs stay at zero so its result is the offset scaled by the gain
  reactive_power_datapath u_reactive_power_datapath (.i_clk, .i_sys_rst,
    .i_volt_a(va), .i_volt_b(vb), .i_volt_c(24'h0), .i_curr_q_a(ia), .i_curr_q_b(ib),
    .i_curr_q_c(24'h0), .i_fvolt_a(va), .i_fvolt_b(vb), .i_fvolt_c(24'h0),
    .i_fcurr_q_a(ia), .i_fcurr_q_b(ib), .i_fcurr_q_c(24'h0), .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_phase_a_inst_q(qa), .o_phase_b_inst_q(qb), .o_phase_c_inst_q(qc),
    .o_sample);
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobe is held between writes; the next read or wait lowers it
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [5:0] a);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd_v = o_rdata;
    @(posedge i_clk);
  endtask
  task automatic smp(input int n);
    i_wr <= 1'b0;
    repeat (n) begin
      do begin
        @(posedge i_clk);
        #1;
      end while (o_sample !== 1'b1);
    end
    repeat (2) @(posedge i_clk);
  endtask
  task automatic t_reset();
    for (int a = 0; a < 16; a++) begin
      rd(6'(a));
      chk(rd_v, 32'h0);
    end
    $display("reset values done");
  endtask
  task automatic t_regs();
    for (int a = 0; a < 12; a++) begin
      wr(6'(a), 32'hff800000 | a);
      rd(6'(a));
      chk(rd_v, 32'h0f800000 | a);
    end
    for (int a = 0; a < 12; a++) begin
      rd(6'(a));
      chk(rd_v, 32'h0f800000 | a);
    end
    wr(6'h0d, 32'h00123456);
    rd(6'h0d);
    chk(rd_v, 32'h0);
    wr(rq_pkg::CFG_ADDR, 32'h1);
    rd(rq_pkg::CFG_ADDR);
    chk(rd_v, 32'h1);
    for (int a = 0; a < 12; a++) wr(6'(a), 32'h0);
    $display("register access done");
  endtask
  task automatic t_power();
    va <= 24'h400000;
    ia <= 24'h400000;
    vb <= 24'h400000;
    ib <= 24'hc00000;
    wr(rq_pkg::C_TOT_OFS, 32'h100);
    wr(rq_pkg::C_TOT_GAIN, 32'h400000);
    smp(3);
    chk({30'h0, qa[27], |qa}, 32'h1);
    chk({30'h0, qb[27], |qb}, 32'h3);
    chk({4'h0, qc}, 32'h180);
    rd(rq_pkg::A_INST_Q);
    chk({30'h0, rd_v[31], |rd_v}, 32'h1);
    rd(rq_pkg::A_FUND_Q);
    chk({30'h0, rd_v[31], |rd_v}, 32'h1);
    rd(rq_pkg::B_FUND_Q);
    chk({30'h0, rd_v[31], |rd_v}, 32'h3);
    wr(rq_pkg::C_TOT_OFS, 32'hffff00);
    wr(rq_pkg::C_TOT_GAIN, 32'hc00000);
    smp(2);
    chk({4'h0, qc}, 32'h0fffff80);
    $display("power path done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge i_clk);
    err_total++;
    $display("mismatch at %0t: timeout", $time);
    end_of_test();
  end
  initial begin
    i_sys_rst = 1'b1;
    {va, vb, ia, ib} = '0;
    {i_addr, i_wdata, i_wr, i_rd} = '0;
    err_total = 0;
    n_tests = 0;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_power();
    end_of_test();
  end
endmodule
